/* File: hdl/tefl_chan_flags.sv */
// Capture/compare flag and overcapture flag of one timer channel
module tefl_chan_flags (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic is_input,
    input  wire logic hw_capture,
    input  wire logic cmp_set,
    input  wire logic sw_gen,
    input  wire logic flag_clear,
    input  wire logic ovc_clear,
    input  wire logic read_clear,
    output logic      cc_event,
    output logic      capture_ev,
    output logic      flag_q,
    output logic      ovc_q
);

    logic compare_ev;

    assign capture_ev = is_input & (hw_capture | sw_gen);
    assign compare_ev = ~is_input & (cmp_set | sw_gen);
    assign cc_event   = capture_ev | compare_ev;

    // Set wins over any clear arriving in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 1'b0;
        end else if (cc_event) begin
            flag_q <= 1'b1;
        end else if (flag_clear | read_clear) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovc_q <= 1'b0;
        end else if (capture_ev & flag_q) begin
            ovc_q <= 1'b1;
        end else if (ovc_clear) begin
            ovc_q <= 1'b0;
        end
    end

endmodule : tefl_chan_flags

/* File: hdl/tefl_event_ctrl.sv */
// Timer event, status flag, interrupt request and DMA request logic with AHB-Lite registers
//
// Added by the designer: register access over AHB-Lite.
module tefl_event_ctrl (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire tefl_pkg::tefl_core_in_t core_in,
    output tefl_pkg::tefl_core_out_t     core_out,
    output logic                         main_output_on,
    output logic [7:0]                   irq_req,
    output logic [5:0]                   dma_req
);

    // Bus data phase state
    logic        wr_pend_q;
    logic [31:0] addr_q;
    logic [31:0] hrdata_q;
    logic        addr_phase;
    logic [7:0]  wdata;
    logic [7:0]  rd_mux;

    // Software registers
    logic [7:0]  der_q;
    logic [7:0]  ier_q;
    logic        update_inhibit_q;
    logic        update_source_select_q;
    logic        control_preload_on_q;
    logic        channel_dma_on_update_q;
    logic        main_output_on_q;

    // Flags
    logic        break_flag_q;
    logic        trigger_flag_q;
    logic        commutation_flag_q;
    logic        update_flag_q;
    logic [3:0]  chan_flag;
    logic [3:0]  chan_ovc;
    logic [7:0]  sr1;
    logic [7:0]  sr2;

    // Write strobes and event terms
    logic        wr_der;
    logic        wr_ier;
    logic        wr_sr1;
    logic        wr_sr2;
    logic        wr_egr;
    logic        wr_ctrl;
    logic [7:0]  sw_gen;
    logic [7:0]  sr1_clr;
    logic [7:0]  sr2_clr;
    logic        trigger_input_sel_q;
    logic        trig_edge;
    logic        trig_ev;
    logic        com_ev;
    logic        wrap;
    logic        uev;
    logic        update_set;
    logic [3:0]  cmp_set;
    logic [3:0]  cc_event;
    logic [3:0]  capture_ev;
    logic [5:0]  dma_d;
    logic [5:0]  dma_q;
    tefl_pkg::tefl_core_out_t core_out_d;
    tefl_pkg::tefl_core_out_t core_out_q;

    // Bus slave: zero wait states, always OKAY
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_q;
    assign addr_phase = hsel & htrans[1] & hready;
    assign wdata      = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            if (addr_phase) begin
                addr_q <= haddr;
            end
        end
    end

    // Read data is captured at the end of the address phase, so a write still in its
    // data phase is not yet visible; a master running back to back sees the old value
    always_comb begin
        unique case (haddr)
            tefl_pkg::TEFL_DER_ADDR:  rd_mux = der_q;
            tefl_pkg::TEFL_IER_ADDR:  rd_mux = ier_q;
            tefl_pkg::TEFL_SR1_ADDR:  rd_mux = sr1;
            tefl_pkg::TEFL_SR2_ADDR:  rd_mux = sr2;
            tefl_pkg::TEFL_CTRL_ADDR: rd_mux = {3'b000, main_output_on_q,
                                                channel_dma_on_update_q,
                                                control_preload_on_q,
                                                update_source_select_q,
                                                update_inhibit_q};
            default:                  rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (addr_phase & ~hwrite) begin
            hrdata_q <= {24'h000000, rd_mux};
        end
    end

    assign wr_der  = wr_pend_q & (addr_q == tefl_pkg::TEFL_DER_ADDR);
    assign wr_ier  = wr_pend_q & (addr_q == tefl_pkg::TEFL_IER_ADDR);
    assign wr_sr1  = wr_pend_q & (addr_q == tefl_pkg::TEFL_SR1_ADDR);
    assign wr_sr2  = wr_pend_q & (addr_q == tefl_pkg::TEFL_SR2_ADDR);
    assign wr_egr  = wr_pend_q & (addr_q == tefl_pkg::TEFL_EGR_ADDR);
    assign wr_ctrl = wr_pend_q & (addr_q == tefl_pkg::TEFL_CTRL_ADDR);

    // Generation bits act during the write itself and are never stored
    assign sw_gen  = wr_egr ? wdata : 8'h00;
    assign sr1_clr = wr_sr1 ? ~wdata : 8'h00;
    assign sr2_clr = wr_sr2 ? (~wdata & tefl_pkg::TEFL_SR2_MASK) : 8'h00;

    // Enable registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            der_q <= tefl_pkg::TEFL_REG_RESET;
        end else if (wr_der) begin
            der_q <= wdata & tefl_pkg::TEFL_DER_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ier_q <= tefl_pkg::TEFL_REG_RESET;
        end else if (wr_ier) begin
            ier_q <= wdata;
        end
    end

    // Control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            update_inhibit_q        <= tefl_pkg::TEFL_CTRL_RESET[tefl_pkg::TEFL_CTRL_UPD_INHIBIT];
            update_source_select_q  <= tefl_pkg::TEFL_CTRL_RESET[tefl_pkg::TEFL_CTRL_UPD_SOURCE];
            control_preload_on_q    <= tefl_pkg::TEFL_CTRL_RESET[tefl_pkg::TEFL_CTRL_PRELOAD_ON];
            channel_dma_on_update_q <= tefl_pkg::TEFL_CTRL_RESET[tefl_pkg::TEFL_CTRL_DMA_ON_UPD];
        end else if (wr_ctrl) begin
            update_inhibit_q        <= wdata[tefl_pkg::TEFL_CTRL_UPD_INHIBIT];
            update_source_select_q  <= wdata[tefl_pkg::TEFL_CTRL_UPD_SOURCE];
            control_preload_on_q    <= wdata[tefl_pkg::TEFL_CTRL_PRELOAD_ON];
            channel_dma_on_update_q <= wdata[tefl_pkg::TEFL_CTRL_DMA_ON_UPD];
        end
    end

    // A break always beats a software attempt to turn the outputs on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_output_on_q <= tefl_pkg::TEFL_CTRL_RESET[tefl_pkg::TEFL_CTRL_MAIN_OUT_ON];
        end else if (sw_gen[tefl_pkg::TEFL_BIT_BRK] | core_in.brk_active) begin
            main_output_on_q <= 1'b0;
        end else if (wr_ctrl) begin
            main_output_on_q <= wdata[tefl_pkg::TEFL_CTRL_MAIN_OUT_ON];
        end
    end

    assign main_output_on = main_output_on_q;

    // Break flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            break_flag_q <= 1'b0;
        end else if (core_in.brk_active | sw_gen[tefl_pkg::TEFL_BIT_BRK]) begin
            break_flag_q <= 1'b1;
        end else if (sr1_clr[tefl_pkg::TEFL_BIT_BRK]) begin
            break_flag_q <= 1'b0;
        end
    end

    // Trigger edge detection on the selected trigger input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trigger_input_sel_q <= 1'b0;
        end else begin
            trigger_input_sel_q <= core_in.trigger_input_sel;
        end
    end

    assign trig_edge = core_in.trig_gated ? (core_in.trigger_input_sel ^ trigger_input_sel_q)
                                          : (core_in.trigger_input_sel & ~trigger_input_sel_q);
    assign trig_ev   = trig_edge | sw_gen[tefl_pkg::TEFL_BIT_TRG];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trigger_flag_q <= 1'b0;
        end else if (trig_ev) begin
            trigger_flag_q <= 1'b1;
        end else if (sr1_clr[tefl_pkg::TEFL_BIT_TRG]) begin
            trigger_flag_q <= 1'b0;
        end
    end

    // Commutation happens only while the channel controls are preloaded
    assign com_ev = (sw_gen[tefl_pkg::TEFL_BIT_COM] | core_in.com_in)
                  & control_preload_on_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            commutation_flag_q <= 1'b0;
        end else if (com_ev) begin
            commutation_flag_q <= 1'b1;
        end else if (sr1_clr[tefl_pkg::TEFL_BIT_COM]) begin
            commutation_flag_q <= 1'b0;
        end
    end

    // Update event and update flag
    assign wrap       = core_in.ovf | core_in.udf;
    assign uev        = (wrap | sw_gen[tefl_pkg::TEFL_BIT_UPD] | core_in.trig_reinit)
                      & ~update_inhibit_q;
    assign update_set = (wrap & ~update_inhibit_q)
                      | ((sw_gen[tefl_pkg::TEFL_BIT_UPD] | core_in.trig_reinit)
                         & ~update_source_select_q & ~update_inhibit_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            update_flag_q <= 1'b0;
        end else if (update_set) begin
            update_flag_q <= 1'b1;
        end else if (sr1_clr[tefl_pkg::TEFL_BIT_UPD]) begin
            update_flag_q <= 1'b0;
        end
    end

    // Compare beyond reload: flag on overflow counting up or centred, underflow counting down
    always_comb begin
        for (int i = 0; i < tefl_pkg::TEFL_NCH; i++) begin
            cmp_set[i] = core_in.cmp_match[i]
                       | (core_in.cmp_above_arr[i]
                          & ((core_in.count_down & ~core_in.center_align_select)
                             ? core_in.udf : core_in.ovf));
        end
    end

    for (genvar ch = 0; ch < tefl_pkg::TEFL_NCH; ch++) begin : g_chan
        tefl_chan_flags u_chan (
            .hclk       (hclk),
            .hresetn    (hresetn),
            .is_input   (core_in.chan_input[ch]),
            .hw_capture (core_in.capture[ch]),
            .cmp_set    (cmp_set[ch]),
            .sw_gen     (sw_gen[tefl_pkg::TEFL_BIT_CC1 + ch]),
            .flag_clear (sr1_clr[tefl_pkg::TEFL_BIT_CC1 + ch]),
            .ovc_clear  (sr2_clr[tefl_pkg::TEFL_BIT_CC1 + ch]),
            .read_clear (core_in.ccr_low_read[ch]),
            .cc_event   (cc_event[ch]),
            .capture_ev (capture_ev[ch]),
            .flag_q     (chan_flag[ch]),
            .ovc_q      (chan_ovc[ch])
        );
    end

    assign sr1 = {break_flag_q, trigger_flag_q, commutation_flag_q, chan_flag, update_flag_q};
    assign sr2 = {3'b000, chan_ovc, 1'b0};

    // Interrupt requests are the flag gated by its enable
    assign irq_req = sr1 & ier_q;

    // DMA requests come from the events, so enabling on a set flag gives nothing
    assign dma_d[tefl_pkg::TEFL_BIT_UPD] = update_set & der_q[tefl_pkg::TEFL_BIT_UPD];
    assign dma_d[tefl_pkg::TEFL_BIT_COM] = com_ev & der_q[tefl_pkg::TEFL_BIT_COM];
    assign dma_d[tefl_pkg::TEFL_BIT_CC4:tefl_pkg::TEFL_BIT_CC1] =
        (channel_dma_on_update_q ? {4{uev}} : cc_event)
        & der_q[tefl_pkg::TEFL_BIT_CC4:tefl_pkg::TEFL_BIT_CC1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_q <= 6'h00;
        end else begin
            dma_q <= dma_d;
        end
    end

    assign dma_req = dma_q;

    // Commands to the counter core, one cycle after their cause
    always_comb begin
        core_out_d                  = '0;
        core_out_d.uev              = uev;
        core_out_d.cnt_reinit       = sw_gen[tefl_pkg::TEFL_BIT_UPD];
        core_out_d.psc_clear        = sw_gen[tefl_pkg::TEFL_BIT_UPD];
        core_out_d.reinit_to_reload = sw_gen[tefl_pkg::TEFL_BIT_UPD]
                                    & core_in.count_down
                                    & ~core_in.center_align_select;
        core_out_d.com_transfer     = com_ev;
        core_out_d.trig_event       = trig_ev;
        core_out_d.sw_capture       = capture_ev
                                    & sw_gen[tefl_pkg::TEFL_BIT_CC4:tefl_pkg::TEFL_BIT_CC1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_out_q <= '0;
        end else begin
            core_out_q <= core_out_d;
        end
    end

    assign core_out = core_out_q;

endmodule : tefl_event_ctrl

/* File: pkg/tefl_pkg.sv */
// Package with register map, field positions and carrier types of the timer event block
package tefl_pkg;

    // Printed offsets are register indices; the byte address is four times the index
    localparam logic [7:0]  TEFL_DER_IDX   = 8'h04;
    localparam logic [7:0]  TEFL_IER_IDX   = 8'h05;
    localparam logic [7:0]  TEFL_SR1_IDX   = 8'h06;
    localparam logic [7:0]  TEFL_SR2_IDX   = 8'h07;
    localparam logic [7:0]  TEFL_EGR_IDX   = 8'h08;
    localparam logic [7:0]  TEFL_CTRL_IDX  = 8'h20;
    localparam logic [31:0] TEFL_DER_ADDR  = {22'h000000, TEFL_DER_IDX, 2'b00};
    localparam logic [31:0] TEFL_IER_ADDR  = {22'h000000, TEFL_IER_IDX, 2'b00};
    localparam logic [31:0] TEFL_SR1_ADDR  = {22'h000000, TEFL_SR1_IDX, 2'b00};
    localparam logic [31:0] TEFL_SR2_ADDR  = {22'h000000, TEFL_SR2_IDX, 2'b00};
    localparam logic [31:0] TEFL_EGR_ADDR  = {22'h000000, TEFL_EGR_IDX, 2'b00};
    localparam logic [31:0] TEFL_CTRL_ADDR = {22'h000000, TEFL_CTRL_IDX, 2'b00};

    // Reset values
    localparam logic [7:0]  TEFL_REG_RESET = 8'h00;
    localparam logic [4:0]  TEFL_CTRL_RESET = 5'h00;

    // Bit positions shared by enables, flags and event generation
    localparam int unsigned TEFL_BIT_UPD  = 0;
    localparam int unsigned TEFL_BIT_CC1  = 1;
    localparam int unsigned TEFL_BIT_CC4  = 4;
    localparam int unsigned TEFL_BIT_COM  = 5;
    localparam int unsigned TEFL_BIT_TRG  = 6;
    localparam int unsigned TEFL_BIT_BRK  = 7;
    localparam logic [7:0]  TEFL_DER_MASK = 8'h3F;
    localparam logic [7:0]  TEFL_SR2_MASK = 8'h1E;

    // Control register fields
    localparam int unsigned TEFL_CTRL_UPD_INHIBIT = 0;
    localparam int unsigned TEFL_CTRL_UPD_SOURCE  = 1;
    localparam int unsigned TEFL_CTRL_PRELOAD_ON  = 2;
    localparam int unsigned TEFL_CTRL_DMA_ON_UPD  = 3;
    localparam int unsigned TEFL_CTRL_MAIN_OUT_ON = 4;

    // Number of capture/compare channels
    localparam int unsigned TEFL_NCH = 4;

    // Events and levels coming from the counter core and slave controller
    typedef struct packed {
        logic       ovf;
        logic       udf;
        logic       trig_reinit;
        logic       com_in;
        logic       trigger_input_sel;
        logic       trig_gated;
        logic       brk_active;
        logic       count_down;
        logic       center_align_select;
        logic [3:0] cmp_match;
        logic [3:0] cmp_above_arr;
        logic [3:0] capture;
        logic [3:0] chan_input;
        logic [3:0] ccr_low_read;
    } tefl_core_in_t;

    // One-cycle commands back to the counter core
    typedef struct packed {
        logic       uev;
        logic       cnt_reinit;
        logic       reinit_to_reload;
        logic       psc_clear;
        logic       com_transfer;
        logic       trig_event;
        logic [3:0] sw_capture;
    } tefl_core_out_t;

endpackage : tefl_pkg

/* File: test/tefl_checker.sv */
// Checker of request gating and software event effects at the block's ports
module tefl_checker (
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire logic                     hsel,
    input wire logic [31:0]              haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [31:0]              hwdata,
    input wire logic                     hready,
    input wire tefl_pkg::tefl_core_in_t  core_in,
    input wire tefl_pkg::tefl_core_out_t core_out,
    input wire logic                     main_output_on,
    input wire logic [7:0]               irq_req,
    input wire logic [5:0]               dma_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] a_q;
    logic        w_q;
    logic [5:0]  der;
    logic [7:0]  ier;
    logic [3:0]  ctl;
    logic        eg;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Shadows hold software-only bits; hardware-cleared bits are left out on purpose
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_q <= 1'h0;
            a_q <= 32'h0;
            der <= 6'h00;
            ier <= 8'h00;
            ctl <= 4'h0;
        end else begin
            w_q <= hsel && htrans[1] && hready && hwrite;
            a_q <= haddr;
            if (w_q && a_q == tefl_pkg::TEFL_DER_ADDR) der <= hwdata[5:0];
            if (w_q && a_q == tefl_pkg::TEFL_IER_ADDR) ier <= hwdata[7:0];
            if (w_q && a_q == tefl_pkg::TEFL_CTRL_ADDR) ctl <= hwdata[3:0];
        end
    end
    assign eg = w_q && a_q == tefl_pkg::TEFL_EGR_ADDR;
    upd_dma_a: assert property (core_in.ovf && der[0] && !ctl[0] |=> dma_req[0])
        else $error("update dma request missing");
    dma_gate_a: assert property ((dma_req & ~(der | $past(der))) == 6'h00)
        else $error("dma request while disabled");
    irq_gate_a: assert property ((irq_req & ~ier) == 8'h00)
        else $error("interrupt while disabled");
    upd_irq_a: assert property (core_in.ovf && !ctl[0] && ier[0] |=> irq_req[0])
        else $error("update interrupt missing");
    brk_irq_a: assert property (core_in.brk_active && ier[7] |=> irq_req[7] && !main_output_on)
        else $error("break flag or output enable wrong");
    sw_upd_a: assert property (eg && hwdata[0] |=> core_out.cnt_reinit && core_out.psc_clear)
        else $error("software update did not reinit");
    sw_brk_a: assert property (eg && hwdata[7] |=> !main_output_on && irq_req[7] == ier[7])
        else $error("software break effect wrong");
    com_gate_a: assert property (eg && hwdata[5] |=> core_out.com_transfer == ctl[2])
        else $error("commutation transfer gating wrong");
    sw_dir_a: assert property (eg && hwdata[0] && core_in.count_down
        && !core_in.center_align_select |=> core_out.reinit_to_reload)
        else $error("software update reload direction wrong");
    sw_trg_a: assert property (eg && hwdata[6] |=> core_out.trig_event)
        else $error("software trigger not passed on");
    sw_cap_a: assert property (eg && hwdata[4] && core_in.chan_input[3]
        |=> core_out.sw_capture[3])
        else $error("software capture not passed on");
    cover property (core_in.ovf && der[0] ##1 dma_req[0]);
    cover property (eg && hwdata[7]);
    cover property (core_in.brk_active ##1 irq_req[7]);
endmodule : tefl_checker

/* File: test/tefl_dma_model.sv */
// DMA controller model that counts request cycles per request line
module tefl_dma_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [5:0] dma_req,
    output int unsigned     cnt [6]
);
    timeunit 1ns;
    timeprecision 1ps;
    // A request standing two cycles counts twice, so a stuck request shows up
    always_ff @(posedge hclk or negedge hresetn) begin
        for (int i = 0; i < 6; i++) begin
            if (!hresetn) begin
                cnt[i] <= 0;
            end else if (dma_req[i]) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule : tefl_dma_model

/* File: test/tefl_event_ctrl_tb_top.sv */
// Bench top: bus tasks and event scenarios for the timer event block
module tefl_event_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DER = tefl_pkg::TEFL_DER_ADDR;
    localparam logic [31:0] IER = tefl_pkg::TEFL_IER_ADDR;
    localparam logic [31:0] SR1 = tefl_pkg::TEFL_SR1_ADDR;
    localparam logic [31:0] SR2 = tefl_pkg::TEFL_SR2_ADDR;
    localparam logic [31:0] EGR = tefl_pkg::TEFL_EGR_ADDR;
    localparam logic [31:0] CTL = tefl_pkg::TEFL_CTRL_ADDR;
    logic                     hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [1:0]               htrans = 2'h0;
    logic [31:0]              haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic                     hreadyout, hresp, main_output_on;
    logic [7:0]               irq_req;
    logic [5:0]               dma_req;
    tefl_pkg::tefl_core_in_t  core_in = '0, lvl = '0;
    tefl_pkg::tefl_core_out_t core_out;
    int unsigned              cnt [6], sv [6];
    int                       error_cnt = 0, tests_run = 0;
    logic [31:0]              adr [7] = '{DER, IER, SR1, SR2, EGR, CTL, 32'h40};
    tefl_event_ctrl i_tefl_event_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .core_in(core_in), .core_out(core_out), .main_output_on(main_output_on),
        .irq_req(irq_req), .dma_req(dma_req));
    tefl_dma_model i_tefl_dma_model (.hclk(hclk), .hresetn(hresetn), .dma_req(dma_req),
        .cnt(cnt));
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for hready; no wait state count is assumed
    task automatic rdy;
        for (int n = 0; n < 50; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'h1) return;
        end
        error_cnt++;
        report_and_stop();
    endtask : rdy
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
        #1;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'h1, d, r);
    endtask : wr
    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'h0, 32'h0, r);
        chk(r, e);
    endtask : rc
    // One-cycle event pulses ride on top of the level inputs held in lvl
    task automatic pul(input tefl_pkg::tefl_core_in_t p);
        @(posedge hclk);
        core_in <= lvl | p;
        @(posedge hclk);
        core_in <= lvl;
        #1;
    endtask : pul
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        foreach (adr[i]) rc(adr[i], 32'h0);
        chk({31'h0, hresp}, 32'h0);
        wr(IER, 32'hFF);
        rc(IER, 32'hFF);
        wr(DER, 32'h3F);
        rc(DER, 32'h3F);
        pul('{ovf: 1'h1, default: 0});
        rc(SR1, 32'h1);
        chk({24'h0, irq_req}, 32'h1);
        wr(DER, 32'h0);
        pul('{ovf: 1'h1, default: 0});
        wr(DER, 32'h3F);
        chk(cnt[0], 32'h1);
        wr(SR1, 32'hFF);
        rc(SR1, 32'h1);
        wr(SR1, 32'hFE);
        rc(SR1, 32'h0);
        wr(CTL, 32'h2);
        pul('{ovf: 1'h1, default: 0});
        rc(SR1, 32'h1);
        wr(SR1, 32'h0);
        wr(EGR, 32'h1);
        pul('{trig_reinit: 1'h1, default: 0});
        rc(SR1, 32'h0);
        wr(CTL, 32'h1);
        pul('{ovf: 1'h1, default: 0});
        wr(EGR, 32'h1);
        rc(SR1, 32'h0);
        wr(CTL, 32'h0);
        wr(EGR, 32'h1);
        rc(SR1, 32'h1);
        chk(cnt[0], 32'h3);
        rc(EGR, 32'h0);
        lvl.brk_active = 1'h1;
        pul('{default: 0});
        wr(SR1, 32'h0);
        rc(SR1, 32'h80);
        lvl.brk_active = 1'h0;
        pul('{default: 0});
        wr(SR1, 32'h0);
        rc(SR1, 32'h0);
        wr(CTL, 32'h10);
        chk({31'h0, main_output_on}, 32'h1);
        wr(EGR, 32'h80);
        chk({31'h0, main_output_on}, 32'h0);
        chk({24'h0, irq_req}, 32'h80);
        wr(SR1, 32'h0);
        wr(EGR, 32'h40);
        rc(SR1, 32'h40);
        wr(SR1, 32'h0);
        lvl.trigger_input_sel = 1'h1;
        pul('{default: 0});
        rc(SR1, 32'h40);
        wr(SR1, 32'h0);
        lvl.trigger_input_sel = 1'h0;
        pul('{default: 0});
        rc(SR1, 32'h0);
        lvl.trig_gated = 1'h1;
        lvl.trigger_input_sel = 1'h1;
        pul('{default: 0});
        wr(SR1, 32'h0);
        // Gated mode: the falling edge must set the flag as well as the rising edge
        lvl.trigger_input_sel = 1'h0;
        pul('{default: 0});
        rc(SR1, 32'h40);
        wr(SR1, 32'h0);
        wr(EGR, 32'h20);
        rc(SR1, 32'h0);
        wr(CTL, 32'h4);
        pul('{com_in: 1'h1, default: 0});
        rc(SR1, 32'h20);
        wr(SR1, 32'h0);
        wr(EGR, 32'h20);
        rc(SR1, 32'h20);
        chk(cnt[5], 32'h2);
        wr(SR1, 32'h0);
        pul('{cmp_match: 4'h1, default: 0});
        rc(SR1, 32'h2);
        lvl.cmp_above_arr = 4'h2;
        wr(SR1, 32'h0);
        pul('{ovf: 1'h1, default: 0});
        rc(SR1, 32'h5);
        lvl.count_down = 1'h1;
        wr(SR1, 32'h0);
        pul('{ovf: 1'h1, default: 0});
        rc(SR1, 32'h1);
        pul('{udf: 1'h1, default: 0});
        rc(SR1, 32'h5);
        wr(SR1, 32'h0);
        wr(EGR, 32'h8);
        rc(SR1, 32'h8);
        lvl.chan_input = 4'h8;
        pul('{capture: 4'h8, default: 0});
        pul('{capture: 4'h9, default: 0});
        rc(SR2, 32'h10);
        pul('{ccr_low_read: 4'h8, default: 0});
        rc(SR1, 32'h8);
        wr(SR2, 32'h0);
        wr(EGR, 32'h10);
        wr(EGR, 32'h10);
        rc(SR2, 32'h10);
        sv = cnt;
        wr(CTL, 32'h8);
        pul('{ovf: 1'h1, default: 0});
        // The request lands one edge after the event and is counted one edge later
        repeat (2) @(posedge hclk);
        for (int i = 1; i < 5; i++) chk(cnt[i] - sv[i], 32'h1);
        wr(EGR, 32'h1);
        report_and_stop();
    end
endmodule : tefl_event_ctrl_tb_top
bind tefl_event_ctrl tefl_checker i_tefl_checker (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .core_in(core_in), .core_out(core_out),
    .main_output_on(main_output_on), .irq_req(irq_req), .dma_req(dma_req));
